// ### core/wwrs_supervisor.sv
`timescale 1ns/100ps
`include "wwrs_defines.svh"
// Notes on behaviour
// - wake is a 50% square wave in each period with no service
// - wake cycles repeat endlessly outside reset
// - only falling watchdog edges count, watched only in the run state
// - first edge forces wake low for the cycle
// - later edges in same cycle are ignored
// - no edge in a cycle gives reset pulse
// - reset held until output reported in regulation
// - undervoltage resets; release after recovery plus delay
// - input too low always asserts reset
// - wake held low whenever reset is asserted
// - wake restarts; first rise after reset-to-wake delay
// - wake period is 4.17e-7 s per ohm
// - reset delay is 5.21e-8 s per ohm
// - enable high turns supply on, low shuts down
module wwrs_supervisor #(
  parameter int unsigned RST_DELAY_CYC = `WWRS_RST_DELAY_CYC
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // pins from outside
  input  wire logic                watchdogServiceIn,
  input  wire logic                enableIn,
  input  wire wwrs_pkg::wwrs_supply_t supplyIn,
  // pins toward host and regulator
  output wwrs_pkg::wwrs_host_t     hostOut,
  output logic                     supplyOn
);
  import wwrs_pkg::*;

  localparam int unsigned RDC = (RST_DELAY_CYC < 1) ? 1 : RST_DELAY_CYC;
  localparam int unsigned R2W_CYC = RDC * `WWRS_R2W_MULT;
  localparam int unsigned WAKE_CYC = RDC * `WWRS_WAKE_MULT;
  localparam int unsigned HALF_CYC = WAKE_CYC / 2;
  localparam logic [`WWRS_CNT_W-1:0] RDC_L = RDC[`WWRS_CNT_W-1:0];
  localparam logic [`WWRS_CNT_W-1:0] R2W_L = R2W_CYC[`WWRS_CNT_W-1:0];
  localparam logic [`WWRS_CNT_W-1:0] WAKE_L = WAKE_CYC[`WWRS_CNT_W-1:0];
  localparam logic [`WWRS_CNT_W-1:0] HALF_L = HALF_CYC[`WWRS_CNT_W-1:0];

  // synchronisers for pin inputs
  logic [1:0] wdSync;
  logic [1:0] enSync;
  logic [1:0] goodSync;
  logic [1:0] underSync;
  logic [1:0] lowSync;
  logic       wdPrev;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wdSync    <= 2'h3;
      enSync    <= 2'h0;
      goodSync  <= 2'h0;
      underSync <= 2'h0;
      lowSync   <= 2'h3;
      wdPrev    <= 1'h1;
    end else begin
      wdSync    <= {wdSync[0], watchdogServiceIn};
      enSync    <= {enSync[0], enableIn};
      goodSync  <= {goodSync[0], supplyIn.outGood};
      underSync <= {underSync[0], supplyIn.outUnder};
      lowSync   <= {lowSync[0], supplyIn.inLow};
      wdPrev    <= wdSync[1];
    end
  end

  // decoded conditions
  wire enabled   = enSync[1];
  wire wdFall    = wdPrev & ~wdSync[1];
  wire inLow     = lowSync[1];
  wire outBad    = underSync[1] | ~goodSync[1];
  wire forceRst  = ~enabled | inLow | outBad;

  assign supplyOn = enabled;

  // state, one shared counter, serviced flag
  wwrs_state_t              state;
  wwrs_state_t              next_state;
  logic [`WWRS_CNT_W-1:0]   cnt;
  logic [`WWRS_CNT_W-1:0]   next_cnt;
  logic                     served;
  logic                     next_served;

  wire cntEnd  = (state == WWRS_RDELAY) ? (cnt == RDC_L - 1'b1) :
                 (state == WWRS_R2W)    ? (cnt == R2W_L - 1'b1) :
                 (cnt == WAKE_L - 1'b1);
  wire missed  = (state == WWRS_RUN) & cntEnd & ~served & ~wdFall;

  // next state and counter
  always_comb begin
    next_state  = state;
    next_cnt    = cnt + 1'b1;
    next_served = served;
    case (state)
      WWRS_HOLD: begin
        next_cnt = '0;
        if (!forceRst) begin
          next_state = WWRS_RDELAY;
        end
      end
      WWRS_RDELAY: begin
        if (cntEnd) begin
          next_state = WWRS_R2W;
          next_cnt   = '0;
        end
      end
      WWRS_R2W: begin
        next_served = 1'b0;
        if (cntEnd) begin
          next_state = WWRS_RUN;
          next_cnt   = '0;
        end
      end
      WWRS_RUN: begin
        if (wdFall) begin
          next_served = 1'b1;
        end
        if (missed) begin
          next_state = WWRS_HOLD;
          next_cnt   = '0;
        end else if (cntEnd) begin
          next_cnt    = '0;
          next_served = 1'b0;
        end
      end
      default: begin
        next_state = WWRS_HOLD;
        next_cnt   = '0;
      end
    endcase
    if (forceRst) begin
      next_state  = WWRS_HOLD;
      next_cnt    = '0;
      next_served = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state  <= WWRS_HOLD;
      cnt    <= '0;
      served <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      served <= next_served;
    end
  end

  // outputs from flip-flops
  wire next_rstN = (next_state == WWRS_R2W) | (next_state == WWRS_RUN);
  wire next_wake = (next_state == WWRS_RUN) & ~next_served &
                   (next_cnt < HALF_L);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hostOut <= '0;
    end else begin
      hostOut.resetOutN <= next_rstN;
      hostOut.wake      <= next_wake;
    end
  end

  // checks
  a_wake_low_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    !hostOut.resetOutN |-> !hostOut.wake)
    else $error("wake high during reset");
  a_inlow_forces_rst: assert property (@(posedge core_clk) disable iff (!resetn)
    inLow |=> !hostOut.resetOutN)
    else $error("reset not asserted on input low");
  a_service_kills_wake: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (state == WWRS_RUN && wdFall && !forceRst && !cntEnd)
    |=> !hostOut.wake)
    else $error("wake not forced low after service");
  a_missed_gives_rst: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (missed && !forceRst) |=> !hostOut.resetOutN)
    else $error("no reset after missed service");
  a_served_sticks: assert property (@(posedge core_clk) disable iff (!resetn)
    (served && state == WWRS_RUN && !cntEnd && !forceRst) |=> served)
    else $error("service flag lost mid cycle");
  a_delay_after_good: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (state == WWRS_HOLD && !forceRst) |=> state == WWRS_RDELAY)
    else $error("no reset delay after recovery");
  a_en_drives_supply: assert property (@(posedge core_clk)
    disable iff (!resetn)
    !enabled |-> !supplyOn ##1 !hostOut.resetOutN)
    else $error("shutdown not honoured");
  a_r2w_no_wake: assert property (@(posedge core_clk) disable iff (!resetn)
    state == WWRS_R2W |-> !hostOut.wake)
    else $error("wake rose before reset-to-wake delay");
  a_cnt_bound: assert property (@(posedge core_clk) disable iff (!resetn)
    cnt < WAKE_L)
    else $error("counter beyond wake period");

  // helper counters so the checks can speak about long stretches
  // without unrolling huge repetitions
  logic [`WWRS_CNT_W-1:0]   wakeRun;
  logic [`WWRS_CNT_W-1:0]   rstRun;
  logic [`WWRS_CNT_W-1:0]   highRun;

  // run lengths of wake high, reset low and reset high
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wakeRun <= '0;
      rstRun  <= '0;
      highRun <= '0;
    end else begin
      wakeRun <= hostOut.wake ? (wakeRun + 1'b1) : '0;
      rstRun  <= hostOut.resetOutN ? '0 : (rstRun + 1'b1);
      highRun <= hostOut.resetOutN ? (highRun + 1'b1) : '0;
    end
  end

  // steps of a reset release and of a missed service
  sequence s_release;
    $rose(hostOut.resetOutN);
  endsequence
  sequence s_quiet_wake;
    !hostOut.wake [*4];
  endsequence
  sequence s_miss;
    missed && !forceRst;
  endsequence
  sequence s_hold_low;
    !hostOut.resetOutN [*2];
  endsequence

  // wake never stays high past half a period
  a_wake_half_len: assert property (@(posedge core_clk)
    disable iff (!resetn)
    hostOut.wake |-> (wakeRun < HALF_L))
    else $error("wake high longer than half a period");
  // every wake rise starts a fresh period
  a_wake_rise_start: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(hostOut.wake) |-> (state == WWRS_RUN && cnt == '0))
    else $error("wake rose away from period start");
  // the period counter wraps only at its terminal count
  a_period_wrap: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (state == WWRS_RUN && !cntEnd && !forceRst) |=> cnt != '0)
    else $error("wake period cut short");
  // the service flag only rises from a detected falling edge
  a_served_by_edge: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(served) |-> $past(wdFall))
    else $error("service flag set without an edge");
  // once served, wake stays low for the rest of the period
  a_served_wake_low: assert property (@(posedge core_clk)
    disable iff (!resetn)
    (served && state == WWRS_RUN && !cntEnd) |=> !hostOut.wake)
    else $error("wake rose again after service");
  // a missed period holds reset low for the next two cycles
  a_miss_pulse: assert property (@(posedge core_clk)
    disable iff (!resetn)
    s_miss |=> s_hold_low)
    else $error("reset pulse after miss too short");
  // no regulation report keeps reset low
  a_good_holds_rst: assert property (@(posedge core_clk)
    disable iff (!resetn)
    !goodSync[1] |=> !hostOut.resetOutN)
    else $error("reset released before regulation");
  // undervoltage asserts reset
  a_under_holds_rst: assert property (@(posedge core_clk)
    disable iff (!resetn)
    underSync[1] |=> !hostOut.resetOutN)
    else $error("reset not asserted on undervoltage");
  // release only after a full reset delay of low time
  a_release_len: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(hostOut.resetOutN) |-> (rstRun >= RDC_L))
    else $error("reset released before the delay");
  // release lands at the start of the reset-to-wake wait
  a_release_state: assert property (@(posedge core_clk)
    disable iff (!resetn)
    s_release |-> (state == WWRS_R2W && cnt == '0))
    else $error("reset released outside delay end");
  // wake stays quiet right after release
  a_quiet_after_rel: assert property (@(posedge core_clk)
    disable iff (!resetn)
    s_release |-> s_quiet_wake)
    else $error("wake rose right after release");
  // first wake rise follows release by the reset-to-wake delay
  a_first_wake_gap: assert property (@(posedge core_clk)
    disable iff (!resetn)
    ($rose(hostOut.wake) && $past(state) == WWRS_R2W)
    |-> (highRun == R2W_L))
    else $error("first wake rise at wrong delay");
  // watchdog edges are read only from the second sync stage
  a_sync_edge: assert property (@(posedge core_clk)
    disable iff (!resetn)
    wdFall |-> !wdSync[1])
    else $error("edge seen before synchronisation");
endmodule // wwrs_supervisor

// ### inc/wwrs_defines.svh
`ifndef WWRS_DEFINES_SVH
`define WWRS_DEFINES_SVH
// timing resistor in ohms, default plain value
`define WWRS_RDELAY_OHM 60000
// timebase: one tick per reset delay unit (5.21e-8 s/ohm), in picoseconds
`define WWRS_RST_DELAY_PS_PER_OHM 52100
`define WWRS_WAKE_PS_PER_OHM 417000
`define WWRS_R2W_PS_PER_OHM 208000
`define WWRS_CLK_PERIOD_PS 100000
// reset delay in cycles (longest time rounds down, at least one)
`define WWRS_RST_DELAY_CYC ((`WWRS_RDELAY_OHM * `WWRS_RST_DELAY_PS_PER_OHM) / `WWRS_CLK_PERIOD_PS)
// reset-to-wake and wake period are four and eight reset delays
`define WWRS_R2W_MULT 4
`define WWRS_WAKE_MULT 8
`define WWRS_HOST_WAIT_NS 5000
`define WWRS_CNT_W 32
`endif

// ### inc/wwrs_pkg.sv
package wwrs_pkg;
  // supervisor state
  typedef enum logic [1:0] {
    WWRS_HOLD,
    WWRS_RDELAY,
    WWRS_R2W,
    WWRS_RUN
  } wwrs_state_t;
  // status flags from the analog side
  typedef struct packed {
    logic outGood;
    logic outUnder;
    logic inLow;
  } wwrs_supply_t;
  // pin outputs toward the host
  typedef struct packed {
    logic wake;
    logic resetOutN;
  } wwrs_host_t;
endpackage

// ### sim/tb_wake_watchdog_reset_supervisor.sv
`timescale 1ns/100ps
module tb_wake_watchdog_reset_supervisor;
  import wwrs_pkg::*;
  localparam int R = 16; // short reset delay, period 8*R
  logic         core_clk = 1'b0;
  logic         resetn   = 1'b0;
  logic         wdog;
  logic         enableIn = 1'b1;
  logic         serve    = 1'b0;
  logic         twice    = 1'b0;
  logic [7:0]   lag      = 8'h64;
  wwrs_supply_t supplyIn = 3'h0;
  wwrs_host_t   hostOut;
  logic         supplyOn;
  int           num_errors = 0;
  int           checks     = 0;
  int           n;
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  wwrs_supervisor #(.RST_DELAY_CYC(R)) dut_u (.core_clk(core_clk),
    .resetn(resetn), .watchdogServiceIn(wdog), .enableIn(enableIn),
    .supplyIn(supplyIn), .hostOut(hostOut), .supplyOn(supplyOn));
  wwrs_host_model host_u (.core_clk(core_clk), .wake(hostOut.wake),
    .serve(serve), .twice(twice), .lag(lag), .wdog(wdog));
  // verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t level %b expected %b", $time, got, exp);
    end
  endtask
  // bounded wait for an output bit, counting cycles
  task automatic waitBit(input int i, input logic v, input int lim);
    n = 0;
    while (hostOut[i] !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic powerUp();
    repeat (20) @(negedge core_clk);
    chkBit(hostOut.resetOutN, 1'b0);
    chkBit(supplyOn, 1'b1);
    @(posedge core_clk) supplyIn <= 3'h4;
    waitBit(0, 1'b1, 40);
    chk(n, R, R + 6);
    waitBit(1, 1'b1, 9 * R);
    chk(n, 4 * R - 1, 4 * R + 1);
    waitBit(1, 1'b0, 9 * R);
    chk(n, 4 * R - 1, 4 * R + 1);
    waitBit(1, 1'b1, 9 * R);
    chk(n, 4 * R - 1, 4 * R + 1);
  endtask
  task automatic serviced();
    @(posedge core_clk) twice <= 1'b1;
    lag <= 8'h32;
    waitBit(1, 1'b0, 9 * R);
    repeat (3) begin
      waitBit(1, 1'b1, 9 * R);
      waitBit(1, 1'b0, 9 * R);
      chk(n, 52, 55);
      repeat (12) @(negedge core_clk);
      chkBit(hostOut.wake, 1'b0);
      chkBit(hostOut.resetOutN, 1'b1);
    end
  endtask
  task automatic missed();
    @(posedge core_clk) serve <= 1'b0;
    waitBit(1, 1'b1, 9 * R);
    waitBit(0, 1'b0, 9 * R);
    chk(n, 8 * R - 2, 8 * R + 4);
    chkBit(hostOut.wake, 1'b0);
    @(posedge core_clk) serve <= 1'b1;
    waitBit(0, 1'b1, 4 * R);
    chk(n, R - 1, R + 6);
  endtask
  // output under, input low, then enable low
  task automatic faults();
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      if (k == 0) supplyIn <= 3'h6;
      else if (k == 1) supplyIn <= 3'h5;
      else enableIn <= 1'b0;
      waitBit(0, 1'b0, 8);
      chkBit(hostOut.wake, 1'b0);
      if (k == 2) chkBit(supplyOn, 1'b0);
      repeat (3 * R) @(negedge core_clk);
      chkBit(hostOut.resetOutN, 1'b0);
      @(posedge core_clk);
      supplyIn <= 3'h4;
      enableIn <= 1'b1;
      waitBit(0, 1'b1, 3 * R);
      chk(n, R, R + 8);
    end
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    serve  <= 1'b1;
    powerUp();
    serviced();
    missed();
    faults();
    wrap_up();
  end
endmodule // tb_wake_watchdog_reset_supervisor

// ### sim/wwrs_host_model.sv
`timescale 1ns/100ps
// host stand-in: answers each wake rise with watchdog pulses while serve is high
module wwrs_host_model (
  // clock
  input  wire logic       core_clk,
  // from supervisor and bench
  input  wire logic       wake,
  input  wire logic       serve,
  input  wire logic       twice,
  input  wire logic [7:0] lag,
  // watchdog pin, driven high when idle
  output logic            wdog
);
  // wait lag cycles after the rise, then one or two low pulses
  initial begin
    wdog = 1'b1;
    forever begin
      @(posedge wake);
      if (serve) begin
        repeat (lag) @(posedge core_clk);
        wdog <= 1'b0;
        repeat (2) @(posedge core_clk);
        wdog <= 1'b1;
        if (twice) begin
          repeat (2) @(posedge core_clk);
          wdog <= 1'b0;
          repeat (2) @(posedge core_clk);
          wdog <= 1'b1;
        end
      end
    end
  end
endmodule // wwrs_host_model
